/* File: core/isscp_pkg.sv */
// Constants, field layout and state codes for the serial register port
// and synthesizer configuration block.
// Assumes one 50 MHz core clock; everything else is sampled into it.
package isscp_pkg;

  // ==========================================================
  // Register map
  localparam int REG_COUNT = 20;
  localparam logic [7:0] ADDR_MAIN_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CLOCK_OUT_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_SYNTH_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_CARRIER_HIGH = 8'h0b;
  localparam logic [7:0] ADDR_CARRIER_MID = 8'h0c;
  localparam logic [7:0] ADDR_CARRIER_LOW = 8'h0d;
  localparam logic [7:0] ADDR_TX_DATA = 8'h13;

  localparam logic [7:0] RESET_MAIN_CONFIG = 8'h10;
  localparam logic [7:0] RESET_CLOCK_OUT_CONFIG = 8'h80;
  localparam logic [7:0] RESET_OTHER = 8'h00;

  // ==========================================================
  // Field positions
  localparam int XDIV_LSB = 4;
  localparam int CODELAY_LSB = 6;
  localparam int LOBAND_LSB = 0;
  localparam int FRAC_BIT = 2;

  // ==========================================================
  // Encodings
  localparam logic [6:0] DEV_ADDR = 7'h69;
  localparam logic [1:0] XDIV_13M0 = 2'h0;
  localparam logic [1:0] XDIV_16M0 = 2'h1;
  localparam logic [1:0] XDIV_19M2 = 2'h2;
  localparam logic [2:0] RATIO_13M0 = 3'h4;
  localparam logic [2:0] RATIO_16M0 = 3'h5;
  localparam logic [2:0] RATIO_19M2 = 3'h6;
  localparam logic [1:0] LOBAND_WIDE = 2'h0;
  localparam logic [1:0] LOBAND_HIGH = 2'h1;
  localparam logic [1:0] LOBAND_MID = 2'h2;
  localparam logic [1:0] LOBAND_LOW = 2'h3;
  localparam logic [7:0] RATIO_MIN = 8'h0b;
  localparam logic [7:0] RATIO_MAX = 8'h48;

  // ==========================================================
  // Timing
  localparam int CORE_CLK_HZ = 50000000;
  localparam int TIMEBASE_HZ = 3200000;
  localparam int BUFFERED_CLOCK_OUT_HZ = 800000;
  localparam int SCL_MAX_HZ = 1000000;
  localparam int BUFFERED_CLOCK_OUT_HALF_TICKS = TIMEBASE_HZ / BUFFERED_CLOCK_OUT_HZ / 2;
  localparam int SCL_HALF_CYCLES = CORE_CLK_HZ / SCL_MAX_HZ / 2;
  localparam int DELAY_SHIFT = 8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR = 3'b010,
    ST_WR = 3'b011,
    ST_RD = 3'b100,
    ST_SKIP = 3'b101
  } isscp_state_t;

  function automatic logic [7:0] isscp_reset_value(input int idx);
    if (idx == int'(ADDR_MAIN_CONFIG)) return RESET_MAIN_CONFIG;
    if (idx == int'(ADDR_CLOCK_OUT_CONFIG)) return RESET_CLOCK_OUT_CONFIG;
    return RESET_OTHER;
  endfunction : isscp_reset_value

endpackage : isscp_pkg

/* File: core/isscp_timebase.sv */
// Crystal divider to the internal time base, and the buffered clock out.
// Assumes xtal_rise is a one-cycle pulse per synchronised crystal rising edge.
`timescale 1ns/10ps
`default_nettype none
module isscp_timebase
  import isscp_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic xtal_rise,
  input wire logic [1:0] div_select,
  input wire logic preset_mode,
  input wire logic [1:0] out_delay,
  output logic tick,
  output logic buffered_clock_out
);

  // ==========================================================
  // Crystal divider
  logic [2:0] xcnt;
  logic [1:0] hcnt;
  logic [9:0] dcnt;
  logic started;
  // Unused code 11 falls back to the smallest ratio
  wire [2:0] div_last = (div_select == XDIV_19M2) ? RATIO_19M2 - 3'h1 :
                        (div_select == XDIV_16M0) ? RATIO_16M0 - 3'h1 :
                        RATIO_13M0 - 3'h1;
  wire div_wrap = xcnt >= div_last;
  wire [9:0] delay_ticks = 10'(out_delay) << DELAY_SHIFT;
  wire half_done = hcnt == 2'(BUFFERED_CLOCK_OUT_HALF_TICKS - 1);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xcnt <= 3'h0;
      tick <= 1'b0;
    end else begin
      tick <= xtal_rise && div_wrap; // [R1]
      if (xtal_rise) begin
        xcnt <= div_wrap ? 3'h0 : xcnt + 3'h1;
      end
    end
  end

  // ==========================================================
  // Clock out, preset mode only, started after the programmed delay
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dcnt <= 10'h000;
      hcnt <= 2'h0;
      started <= 1'b0;
      buffered_clock_out <= 1'b0;
    end else if (!preset_mode) begin
      dcnt <= 10'h000; // [R21]
      hcnt <= 2'h0;
      started <= 1'b0;
      buffered_clock_out <= 1'b0;
    end else if (!started) begin
      if (tick) begin
        started <= dcnt == delay_ticks; // [R21]
        dcnt <= dcnt + 10'h001;
      end
    end else if (tick) begin
      hcnt <= half_done ? 2'h0 : hcnt + 2'h1;
      if (half_done) begin
        buffered_clock_out <= ~buffered_clock_out; // [R20]
      end
    end
  end

  // ==========================================================
  // Checks
  divider_wrap_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
    xtal_rise && div_wrap |=> tick && xcnt == 3'h0)
    else $error("time base tick missing at divider wrap");
  buffered_clock_out_toggle_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R20]
    preset_mode && started && tick && half_done |=> buffered_clock_out != $past(buffered_clock_out))
    else $error("clock out failed to toggle");
  buffered_clock_out_quiet_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R21]
    !preset_mode |=> !buffered_clock_out && !started)
    else $error("clock out active outside preset mode");

endmodule : isscp_timebase
`default_nettype wire

/* File: core/isscp_port.sv */
// Serial register slave with synthesizer and clock configuration fields.
// Assumes scl, sda, crystal clock and mode pins arrive asynchronously;
// sleep_request is a same-domain pulse from the transmit control logic.
//
// Function
// R1 - Divider select 00/01/10 divides crystal by 4/5/6 for the time base.
// R2 - Carrier word is three bytes at 0x0b..0x0d, high byte first.
// R3 - Band select: 0 wide range; 3 low, 2 middle, 1 high band.
// R4 - Fractional enable at 0 gives integer-N, fraction ignored.
// R5 - Integer ratio 11..72 with 16-bit fraction, step crystal/65536.
// R6 - Software should set carrier bit 0 to lower fractional spurs.
// R7 - Serial port only when both mode pins low, else preset mode.
// R8 - Works with master serial clock up to 1 MHz.
// R9 - Each byte is eight data clocks plus one acknowledge clock.
// R10 - Data changes only while clock low; lines idle high.
// R11 - Start is data falling, stop data rising, while clock high.
// R12 - Acknowledge holds data low through the ninth clock high.
// R13 - Master retries later after a missing acknowledge.
// R14 - Fixed address: 0xd2 write byte, 0xd3 read byte.
// R15 - Address match is acknowledged, then direction bit is followed.
// R16 - Write: pointer byte then data bytes, MSB first, each acked.
// R17 - Burst writes go to successive registers until stop.
// R18 - Read: pointer write, repeated start, read address, data MSB first.
// R19 - Master ack reads next register, nack ends; stop closes.
// R20 - Preset mode drives 800 kHz clock on the shared clock pin.
// R21 - Clock out delay at 0x01 bits 7:6 resets to 2, preset only.
// R22 - Writes to 0x13 hold the pointer and push to transmit data.
// R23 - Divider select lives in 0x00, chosen for a 3.2 MHz base.
// R24 - Asleep refuses writes; own address recognition wakes it.
// R25 - Clock and data pass two-stage synchronisers before any logic.
// R26 - Unmatched address leaves data released until next start.
`timescale 1ns/10ps
`default_nettype none
module isscp_port
  import isscp_pkg::*;
#(
  parameter int REGS = REG_COUNT
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic mode_select_pin_a,
  input wire logic mode_select_pin_b,
  input wire logic xtal_clk_in,
  input wire logic sleep_request,
  output logic serial_port_enabled,
  output logic wake_pulse,
  output logic tx_data_strobe,
  output logic [7:0] tx_data_byte,
  output logic [23:0] carrier_word,
  output logic [23:0] synth_divide_word,
  output logic ratio_in_range,
  output logic [1:0] lo_band_select,
  output logic fractional_synth_enable,
  output logic [1:0] xtal_div_select,
  output logic timebase_tick
);

  if (REGS <= int'(ADDR_TX_DATA) || REGS > 32) begin : g_regs_chk
    $error("register count must cover the transmit data register");
  end
  if (SCL_HALF_CYCLES < 4) begin : g_rate_chk // [R8]
    $error("core clock too slow for the serial clock rate");
  end

  // ==========================================================
  // Synchronisers
  localparam int NSYNC = 5;
  wire [NSYNC-1:0] raw = {xtal_clk_in, mode_select_pin_b, mode_select_pin_a, sda_in, scl_in};
  logic [NSYNC-1:0] meta;
  logic [NSYNC-1:0] sync;
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        meta[i] <= 1'b1;
        sync[i] <= 1'b1;
      end else begin
        meta[i] <= raw[i]; // [R25]
        sync[i] <= meta[i]; // [R25]
      end
    end
  end

  logic scl_q;
  logic sda_q;
  logic xtal_q;
  logic port_en;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      xtal_q <= 1'b1;
      port_en <= 1'b0;
    end else begin
      scl_q <= sync[0];
      sda_q <= sync[1];
      xtal_q <= sync[4];
      port_en <= !sync[2] && !sync[3]; // [R7]
    end
  end

  // ==========================================================
  // Bus events, decoded from synchronised samples only
  wire scl_s = sync[0];
  wire sda_s = sync[1];
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire start_det = port_en && scl_s && scl_q && sda_q && !sda_s; // [R11]
  wire stop_det = port_en && scl_s && scl_q && !sda_q && sda_s; // [R11]
  wire ev_rise = port_en && !start_det && !stop_det && scl_rise;
  wire ev_fall = port_en && !start_det && !stop_det && scl_fall;

  isscp_state_t state;
  logic in_ack;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx_shift;
  logic [7:0] ptr;
  logic master_ack;
  logic asleep;
  logic [7:0] regs [REGS];

  wire byte_done = ev_fall && !in_ack && bit_cnt == 4'h8; // [R9]
  wire addr_match = shift[7:1] == DEV_ADDR; // [R14]
  wire addr_ack_fire = byte_done && state == ST_ADDR && addr_match;
  wire wr_fire = byte_done && state == ST_WR && !asleep; // [R24]
  wire ptr_mapped = ptr < 8'(REGS);
  wire ptr_hold = ptr == ADDR_TX_DATA;
  wire [7:0] rd_byte = ptr_mapped ? regs[ptr[4:0]] : 8'h00;
  wire recv_state = state == ST_ADDR || state == ST_PTR || state == ST_WR;

  // ==========================================================
  // Byte engine
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      in_ack <= 1'b0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx_shift <= 8'h00;
      ptr <= 8'h00;
      master_ack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (!port_en) begin
      state <= ST_IDLE; // [R7]
      in_ack <= 1'b0;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      state <= ST_ADDR; // [R11] [R18]
      in_ack <= 1'b0;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state <= ST_IDLE; // [R17] [R19]
      in_ack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ev_rise) begin
      if (!in_ack && recv_state) begin
        shift <= {shift[6:0], sda_s}; // [R16]
        bit_cnt <= bit_cnt + 4'h1;
      end else if (!in_ack && state == ST_RD) begin
        bit_cnt <= bit_cnt + 4'h1;
      end else if (in_ack && state == ST_RD) begin
        master_ack <= !sda_s; // [R19]
      end
    end else if (ev_fall) begin
      if (in_ack) begin
        // End of the ninth clock: release and move to the next byte
        in_ack <= 1'b0;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        unique case (state)
          ST_ADDR: begin
            state <= shift[0] ? ST_RD : ST_PTR; // [R15]
            if (shift[0]) begin
              tx_shift <= rd_byte; // [R18]
              sda_oe <= !rd_byte[7];
              ptr <= ptr + 8'h01;
            end
          end
          ST_PTR: state <= ST_WR; // [R16]
          ST_RD: begin
            if (master_ack) begin
              tx_shift <= rd_byte; // [R19]
              sda_oe <= !rd_byte[7];
              ptr <= ptr + 8'h01;
            end else begin
              state <= ST_SKIP; // [R19]
            end
          end
          ST_IDLE, ST_WR, ST_SKIP: state <= state;
        endcase
      end else if (bit_cnt == 4'h8) begin
        unique case (state)
          ST_ADDR: begin
            if (addr_match) begin
              in_ack <= 1'b1;
              sda_oe <= 1'b1; // [R12] [R15]
            end else begin
              state <= ST_SKIP; // [R26]
            end
          end
          ST_PTR: begin
            ptr <= shift; // [R16]
            in_ack <= 1'b1;
            sda_oe <= 1'b1; // [R12]
          end
          ST_WR: begin
            in_ack <= 1'b1;
            sda_oe <= !asleep; // [R24]
            if (!asleep && !ptr_hold) begin
              ptr <= ptr + 8'h01; // [R17]
            end
          end
          ST_RD: begin
            in_ack <= 1'b1;
            sda_oe <= 1'b0;
          end
          ST_IDLE, ST_SKIP: state <= state;
        endcase
      end else if (state == ST_RD) begin
        sda_oe <= !tx_shift[6]; // [R10] [R18]
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Register file
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < REGS; i++) begin
        regs[i] <= isscp_reset_value(i); // [R21]
      end
    end else if (wr_fire && ptr_mapped) begin
      regs[ptr[4:0]] <= shift; // [R2] [R16]
    end
  end

  // ==========================================================
  // Sleep, wake and transmit data push
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      asleep <= 1'b0;
      wake_pulse <= 1'b0;
      tx_data_strobe <= 1'b0;
      tx_data_byte <= 8'h00;
      sda_out <= 1'b0;
    end else begin
      // Address recognition wins over a sleep request in the same cycle
      asleep <= addr_ack_fire ? 1'b0 : (sleep_request || asleep); // [R24]
      wake_pulse <= addr_ack_fire && asleep; // [R24]
      tx_data_strobe <= wr_fire && ptr_hold; // [R22]
      if (wr_fire && ptr_hold) begin
        tx_data_byte <= shift; // [R22]
      end
      sda_out <= 1'b0;
    end
  end

  // ==========================================================
  // Synthesizer fields
  wire [23:0] cw = {regs[ADDR_CARRIER_HIGH[4:0]], regs[ADDR_CARRIER_MID[4:0]],
                    regs[ADDR_CARRIER_LOW[4:0]]};
  wire frac_en = regs[ADDR_SYNTH_CONTROL[4:0]][FRAC_BIT];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      carrier_word <= 24'h000000;
      synth_divide_word <= 24'h000000;
      ratio_in_range <= 1'b0;
      lo_band_select <= LOBAND_WIDE;
      fractional_synth_enable <= 1'b0;
      xtal_div_select <= XDIV_16M0;
      serial_port_enabled <= 1'b0;
    end else begin
      carrier_word <= cw; // [R2] [R6]
      synth_divide_word <= frac_en ? cw : {cw[23:16], 16'h0000}; // [R4] [R5]
      ratio_in_range <= cw[23:16] >= RATIO_MIN && cw[23:16] <= RATIO_MAX; // [R5]
      lo_band_select <= regs[ADDR_SYNTH_CONTROL[4:0]][LOBAND_LSB +: 2]; // [R3]
      fractional_synth_enable <= frac_en;
      xtal_div_select <= regs[ADDR_MAIN_CONFIG[4:0]][XDIV_LSB +: 2]; // [R23]
      serial_port_enabled <= port_en; // [R7]
    end
  end

  // ==========================================================
  // Time base and shared clock pin
  logic buffered_clock_out;
  wire [1:0] out_delay = regs[ADDR_CLOCK_OUT_CONFIG[4:0]][CODELAY_LSB +: 2];

  isscp_timebase u_timebase (
    .core_clk(core_clk),
    .resetn(resetn),
    .xtal_rise(sync[4] && !xtal_q),
    .div_select(regs[ADDR_MAIN_CONFIG[4:0]][XDIV_LSB +: 2]), // [R1] [R23]
    .preset_mode(!port_en),
    .out_delay(out_delay), // [R21]
    .tick(timebase_tick),
    .buffered_clock_out(buffered_clock_out)
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      scl_out <= buffered_clock_out; // [R20]
      scl_oe <= !port_en; // [R20]
    end
  end

  // ==========================================================
  // Checks
  preset_sda_quiet_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R7]
    !port_en |=> !sda_oe && state == ST_IDLE)
    else $error("data line driven in preset mode");
  shared_pin_dir_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R20]
    port_en |=> !scl_oe)
    else $error("clock pin driven while serial port enabled");
  start_restart_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R11]
    start_det |=> state == ST_ADDR && bit_cnt == 4'h0 && !sda_oe)
    else $error("start did not restart address phase");
  stop_idle_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R11]
    stop_det && !start_det |=> state == ST_IDLE && !sda_oe)
    else $error("stop did not release the bus");
  addr_ack_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R15]
    addr_ack_fire |=> sda_oe && in_ack ##1 (sda_oe throughout (in_ack [*1]))) // [R12]
    else $error("address acknowledge not driven");
  skip_released_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R26]
    state == ST_SKIP |-> !sda_oe)
    else $error("data line driven after unmatched address");
  burst_advance_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R17]
    wr_fire && !ptr_hold |=> ptr == $past(ptr) + 8'h01)
    else $error("burst write pointer did not advance");
  txdata_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R22]
    wr_fire && ptr_hold |=> ptr == ADDR_TX_DATA && tx_data_strobe && tx_data_byte == $past(shift))
    else $error("transmit data write moved the pointer");
  carrier_low_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
    wr_fire && ptr == ADDR_CARRIER_LOW ##2 !wr_fire |-> carrier_word[7:0] == $past(shift, 2))
    else $error("carrier low byte not stored");
  integer_mode_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R4]
    !frac_en |=> synth_divide_word[15:0] == 16'h0000)
    else $error("fraction used in integer mode");
  asleep_nack_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R24]
    byte_done && state == ST_WR && asleep |=> !sda_oe && in_ack)
    else $error("write acknowledged while asleep");

endmodule : isscp_port
`default_nettype wire

/* File: dv/isscp_master.sv */
// Bus master model driving the shared clock and the data line.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module isscp_master (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_low
);
  // ==========================================================
  // Bit timing: 50 core cycles per bit, so 1 MHz
  initial begin
    scl_drv = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt

  // Data moves a quarter bit after the clock falls
  task automatic bit_io(input logic b, output logic r);
    wt(12);
    sda_low <= ~b;
    wt(13);
    scl_drv <= 1'b1;
    wt(25);
    r = sda_line;
    scl_drv <= 1'b0;
  endtask : bit_io

  // Also serves as repeated start from clock low
  task automatic start();
    wt(12);
    sda_low <= 1'b0;
    wt(13);
    scl_drv <= 1'b1;
    wt(25);
    sda_low <= 1'b1;
    wt(25);
    scl_drv <= 1'b0;
  endtask : start

  task automatic stop();
    wt(12);
    sda_low <= 1'b1;
    wt(13);
    scl_drv <= 1'b1;
    wt(25);
    sda_low <= 1'b0;
    wt(25);
  endtask : stop

  // Eight bits MSB first, ninth clock returns the ack
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = (r === 1'b0);
  endtask : send

  // Master ack asks for the next register, nack ends
  task automatic recv(input logic m_ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~m_ack, r);
  endtask : recv
endmodule : isscp_master
`default_nettype wire

/* File: dv/isscp_port_tb.sv */
// Self-checking bench for the serial register port.
// Assumes the master model in isscp_master.sv; crystal runs at 160 ns.
`timescale 1ns/10ps
`default_nettype none
module isscp_port_tb
  import isscp_pkg::*;
;
  logic core_clk, resetn, pin_a, pin_b, xtal, sleep_req, m_scl, m_sda_low, ack;
  logic scl_out, scl_oe, sda_out, sda_oe, spe, wake, txs, rir, frac, tick;
  logic [7:0] txb, rd;
  logic [23:0] cw, sdw;
  logic [1:0] band, xds;
  wire scl_line, sda_line;
  int n_fail = 0;
  int comparisons = 0;
  int n_strobe = 0;
  int n_wake = 0;
  int n;
  logic [7:0] hv [4] = '{8'h0a, 8'h0b, 8'h48, 8'h49};
  logic rv [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  // ==========================================================
  // Open-drain resolution with pull-ups
  assign scl_line = scl_oe ? scl_out : m_scl;
  // Slave side shows its own output level while enabled
  assign sda_line = m_sda_low ? 1'b0 : sda_oe ? sda_out : 1'b1;

  isscp_port i_isscp_port (.core_clk(core_clk), .resetn(resetn), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .mode_select_pin_a(pin_a), .mode_select_pin_b(pin_b), .xtal_clk_in(xtal),
    .sleep_request(sleep_req), .serial_port_enabled(spe), .wake_pulse(wake),
    .tx_data_strobe(txs), .tx_data_byte(txb), .carrier_word(cw), .synth_divide_word(sdw),
    .ratio_in_range(rir), .lo_band_select(band), .fractional_synth_enable(frac),
    .xtal_div_select(xds), .timebase_tick(tick));
  isscp_master i_isscp_master (.core_clk(core_clk), .sda_line(sda_line),
    .scl_drv(m_scl), .sda_low(m_sda_low));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Crystal unrelated in phase to the core clock
  initial begin
    xtal = 1'b0;
    #7;
    forever #80 xtal = ~xtal;
  end
  always @(negedge core_clk) begin
    if (txs === 1'b1) n_strobe++;
    if (wake === 1'b1) n_wake++;
  end

  // ==========================================================
  // Checking and access tasks
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Counts falling core edges until the chosen output reaches lvl
  task automatic wait_lvl(input int sel, input logic lvl, output int cnt);
    logic s;
    cnt = 0;
    do begin
      @(negedge core_clk);
      cnt++;
      s = (sel == 0) ? tick : (sel == 1) ? scl_oe : scl_out;
      if (cnt > 40000) begin
        n_fail++;
        $display("Error at %0t ns: got %h expected %h", $time, s, lvl);
        wrap_up();
      end
    end while (s !== lvl);
  endtask : wait_lvl

  task automatic wr_head(input logic [7:0] ptr);
    i_isscp_master.start();
    i_isscp_master.send(8'hd2, ack);
    check(24'(ack), 24'h1);
    i_isscp_master.send(ptr, ack);
    check(24'(ack), 24'h1);
  endtask : wr_head

  task automatic wr_byte(input logic [7:0] d);
    i_isscp_master.send(d, ack);
    check(24'(ack), 24'h1);
  endtask : wr_byte

  task automatic wr1(input logic [7:0] ptr, input logic [7:0] d);
    wr_head(ptr);
    wr_byte(d);
    i_isscp_master.stop();
  endtask : wr1

  task automatic rd_head(input logic [7:0] ptr);
    wr_head(ptr);
    i_isscp_master.start();
    i_isscp_master.send(8'hd3, ack);
    check(24'(ack), 24'h1);
  endtask : rd_head

  task automatic rd_byte(input logic m_ack, input logic [7:0] exp);
    i_isscp_master.recv(m_ack, rd);
    check(24'(rd), 24'(exp));
  endtask : rd_byte

  // ==========================================================
  // Test sequence
  initial begin
    resetn = 1'b0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    sleep_req = 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (10) @(posedge core_clk);
    check(24'(xds), 24'h1);
    check(24'(spe), 24'h1);
    check(24'(scl_oe), 24'h0);
    rd_head(ADDR_MAIN_CONFIG);
    rd_byte(1'b1, 8'h10);
    rd_byte(1'b0, 8'h80);
    i_isscp_master.stop();
    $display("Test reset values finished");

    wr_head(ADDR_SYNTH_CONTROL);
    wr_byte(8'h06);
    wr_byte(8'h00);
    wr_byte(8'h00);
    wr_byte(8'h20);
    wr_byte(8'h12);
    wr_byte(8'h35);
    i_isscp_master.stop();
    check(cw, 24'h201235);
    check(24'(band), 24'(LOBAND_MID));
    check(sdw, 24'h201235);
    rd_head(ADDR_CARRIER_HIGH);
    rd_byte(1'b1, 8'h20);
    rd_byte(1'b1, 8'h12);
    rd_byte(1'b0, 8'h35);
    i_isscp_master.stop();
    for (int b = 0; b < 4; b++) begin
      wr1(ADDR_SYNTH_CONTROL, {5'h0, b[0], b[1:0]});
      check(24'(band), 24'(b[1:0]));
      check(24'(frac), 24'(b[0]));
      check(sdw, b[0] ? 24'h201235 : 24'h200000);
    end
    for (int i = 0; i < 4; i++) begin
      wr1(ADDR_CARRIER_HIGH, hv[i]);
      check(24'(rir), 24'(rv[i]));
    end
    $display("Test synthesizer fields finished");

    i_isscp_master.start();
    i_isscp_master.send(8'ha4, ack);
    check(24'(ack), 24'h0);
    i_isscp_master.send(8'h00, ack);
    check(24'(ack), 24'h0);
    i_isscp_master.stop();
    wr1(ADDR_CARRIER_LOW, 8'h77);
    check(24'(cw[7:0]), 24'h77);
    $display("Test foreign address finished");

    n_strobe = 0;
    wr_head(ADDR_TX_DATA);
    wr_byte(8'ha1);
    wr_byte(8'hb2);
    wr_byte(8'hc3);
    i_isscp_master.stop();
    check(24'(n_strobe), 24'h3);
    check(24'(txb), 24'hc3);
    rd_head(8'h14);
    rd_byte(1'b0, 8'h00);
    i_isscp_master.stop();
    $display("Test transmit data finished");

    // Unused code 11 falls back to divide by 4
    for (int k = 0; k < 4; k++) begin
      wr1(ADDR_MAIN_CONFIG, {2'h0, k[1:0], 4'h0});
      check(24'(xds), 24'(k[1:0]));
      wait_lvl(0, 1'b1, n);
      wait_lvl(0, 1'b1, n);
      check(24'(n), 24'((k == 3 ? 4 : k + 4) * 8));
    end
    $display("Test crystal divider finished");

    n_wake = 0;
    @(posedge core_clk) sleep_req <= 1'b1;
    @(posedge core_clk) sleep_req <= 1'b0;
    i_isscp_master.start();
    i_isscp_master.send(8'hd2, ack);
    check(24'(ack), 24'h1);
    i_isscp_master.send(ADDR_CARRIER_LOW, ack);
    // Sleep inside the transaction: the data byte is refused
    @(posedge core_clk) sleep_req <= 1'b1;
    @(posedge core_clk) sleep_req <= 1'b0;
    i_isscp_master.send(8'h55, ack);
    check(24'(ack), 24'h0);
    i_isscp_master.stop();
    check(24'(cw[7:0]), 24'h77);
    check(24'(n_wake), 24'h1);
    wr1(ADDR_CARRIER_LOW, 8'h55);
    check(24'(cw[7:0]), 24'h55);
    $display("Test wake finished");

    // Either mode pin alone leaves the serial port
    @(posedge core_clk) pin_b <= 1'b1;
    wait_lvl(1, 1'b1, n);
    check(24'(spe), 24'h0);
    @(posedge core_clk) pin_b <= 1'b0;
    wait_lvl(1, 1'b0, n);
    check(24'(spe), 24'h1);
    @(posedge core_clk) pin_a <= 1'b1;
    wait_lvl(1, 1'b1, n);
    check(24'(spe), 24'h0);
    // Clock out high phase lasts two time base ticks once started
    wait_lvl(2, 1'b1, n);
    wait_lvl(2, 1'b0, n);
    check(24'(n), 24'(2 * 4 * 8));
    $display("Test preset clock finished");
    wrap_up();
  end
endmodule : isscp_port_tb
`default_nettype wire
